/* File: hw/tfs_framer.sv */
// twelve-frame t1 multiframe builder and aligner
// assumes line bit strobes come from logic on CLK_IN; RX_LINE_IN is a pin
`timescale 1ns/1ps

// Functional notes
// - frames are counted one to twelve and wrap back to one.
// - each frame is one framing bit then 24 channels of 8 bits.
// - odd frames carry the terminal pattern 101010 in the framing bit.
// - even frames carry the signalling pattern 001110 in the framing bit.
// - outside data mode, bit 8 of each channel is the A bit in frame 6 and B bit in frame 12.
// - each channel is one 64 kbps circuit, one octet per frame.
// - data mode puts 10111YR0 in the last channel, Y low meaning alarm.
// - the R bit of the sync byte is passed through without meaning.
module tfs_framer #(
  parameter int LOCK_FRAMES = 4,
  parameter int LOSS_ERRORS = 2
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // mode
  input wire logic DATA_MODE_IN,
  // transmit user side
  input wire logic TX_TICK_IN,
  input wire logic [7:0] TX_DATA_IN,
  input wire logic [23:0] TX_SIG_A_IN,
  input wire logic [23:0] TX_SIG_B_IN,
  input wire logic TX_RALARM_IN,
  input wire logic TX_RBIT_IN,
  output logic TX_REQ_OUT,
  output logic [4:0] TX_CHAN_OUT,
  // transmit line side
  output logic TX_BIT_OUT,
  output logic [3:0] TX_FRAME_OUT,
  output logic TX_MF_START_OUT,
  // receive line side
  input wire logic RX_TICK_IN,
  input wire logic RX_LINE_IN,
  // receive user side
  output logic RX_VALID_OUT,
  output tfs_pkg::tfs_rx_octet_s RX_OCTET_OUT,
  output logic RX_FRAME_LOCK_OUT,
  output logic RX_MF_LOCK_OUT,
  output logic RX_RALARM_OUT,
  output logic RX_RBIT_VALID_OUT,
  output logic RX_RBIT_OUT,
  output logic RX_SYNC_ERR_OUT
);

  // ****************************************
  // transmit counters
  // ****************************************
  logic [7:0] tpos_q;
  logic [3:0] tframe_q;
  logic [7:0] thold_q;

  wire t_last = tpos_q == tfs_pkg::LAST_POS;
  wire t_fslot = tpos_q == tfs_pkg::F_POS;
  wire [7:0] tpos_m1 = tpos_q - 8'h01;
  wire [4:0] tchan = tpos_m1[7:3];
  wire [2:0] tidx = tpos_m1[2:0];
  wire t_first = !t_fslot && tidx == 3'h0;
  wire t_req = t_fslot || (tpos_q[2:0] == tfs_pkg::CHAN_END && !t_last);
  wire [4:0] t_req_chan = tpos_q[7:3];
  wire t_sig_frame = tframe_q == tfs_pkg::SIG_A_FRAME ||
                     tframe_q == tfs_pkg::SIG_B_FRAME;
  wire t_sig_bit = (tframe_q == tfs_pkg::SIG_B_FRAME) ?
                   TX_SIG_B_IN[tchan] : TX_SIG_A_IN[tchan];
  wire [7:0] t_sync = tfs_pkg::SYNC_FIXED |
                      (8'(!TX_RALARM_IN) << tfs_pkg::SYNC_Y_BIT) |
                      (8'(TX_RBIT_IN) << tfs_pkg::SYNC_R_BIT);
  wire t_dds_slot = DATA_MODE_IN && tchan == tfs_pkg::LAST_CHAN;
  // the octet is taken on its first bit and held for the other seven
  wire [7:0] t_byte =
    t_dds_slot ? t_sync :
    (!DATA_MODE_IN && t_sig_frame) ? {TX_DATA_IN[7:1], t_sig_bit} :
    TX_DATA_IN;
  wire [7:0] t_cur = t_first ? t_byte : thold_q;
  wire t_line = t_fslot ? tfs_pkg::fbit(tframe_q) : t_cur[3'h7 - tidx];
  wire [3:0] tframe_nx = (tframe_q == tfs_pkg::LAST_FRAME) ?
                         tfs_pkg::FIRST_FRAME : tframe_q + 4'h1;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      tpos_q <= tfs_pkg::F_POS;
      tframe_q <= tfs_pkg::FIRST_FRAME;
      thold_q <= 8'h00;
      TX_REQ_OUT <= 1'b0;
      TX_CHAN_OUT <= 5'h00;
      TX_BIT_OUT <= 1'b0;
      TX_FRAME_OUT <= tfs_pkg::FIRST_FRAME;
      TX_MF_START_OUT <= 1'b0;
    end else begin
      TX_REQ_OUT <= TX_TICK_IN && t_req;
      TX_MF_START_OUT <= TX_TICK_IN && t_fslot &&
                         tframe_q == tfs_pkg::FIRST_FRAME;
      if (TX_TICK_IN) begin
        tpos_q <= t_last ? tfs_pkg::F_POS : tpos_q + 8'h01;
        if (t_last) begin
          tframe_q <= tframe_nx;
        end
        if (t_req) begin
          TX_CHAN_OUT <= t_req_chan;
        end
        if (t_first) begin
          thold_q <= t_byte;
        end
        TX_BIT_OUT <= t_line;
        TX_FRAME_OUT <= tframe_q;
      end
    end
  end

  // ****************************************
  // receive pin synchroniser
  // ****************************************
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic rbit_q;

  // s1_q is read only by s2_q so a metastable level never fans out
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      rbit_q <= 1'b0;
    end else begin
      s1_q <= RX_LINE_IN;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        rbit_q <= s3_q;
      end
    end
  end

  // ****************************************
  // receive alignment
  // ****************************************
  tfs_pkg::tfs_rx_state_e st_q;
  tfs_pkg::tfs_rx_state_e st_d;
  logic [7:0] rpos_q;
  logic [3:0] rframe_q;
  logic [3:0] rframe_d;
  logic [1:0] fhist_q;
  logic [5:0] fs_sr_q;
  logic ph_q;
  logic ph_d;
  logic retry_q;
  logic retry_d;
  logic slip;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [6:0] sh_q;

  wire r_fslot = RX_TICK_IN && rpos_q == tfs_pkg::F_POS;
  wire r_alt = rbit_q != fhist_q[1];
  wire [5:0] fs_next = {fs_sr_q[4:0], rbit_q};
  wire [3:0] rframe_nx = (rframe_q == tfs_pkg::LAST_FRAME) ?
                         tfs_pkg::FIRST_FRAME : rframe_q + 4'h1;
  wire r_fbit_ok = rbit_q == tfs_pkg::fbit(rframe_nx);
  wire [7:0] rpos_m1 = rpos_q - 8'h01;
  wire r_chan_end = RX_TICK_IN && !(rpos_q == tfs_pkg::F_POS) &&
                    rpos_q[2:0] == tfs_pkg::CHAN_END;
  wire [7:0] r_byte = {sh_q, rbit_q};
  wire [4:0] r_chan = rpos_m1[7:3];
  wire r_aligned = st_q != tfs_pkg::RX_FRAME_HUNT;
  wire r_locked = st_q == tfs_pkg::RX_LOCKED;
  wire r_sig = r_locked && !DATA_MODE_IN &&
               (rframe_q == tfs_pkg::SIG_A_FRAME ||
                rframe_q == tfs_pkg::SIG_B_FRAME);
  wire r_dds = r_aligned && DATA_MODE_IN && r_chan == tfs_pkg::LAST_CHAN;
  wire r_sync_ok = (r_byte & tfs_pkg::SYNC_MASK) == tfs_pkg::SYNC_FIXED;

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    retry_d = retry_q;
    cnt_d = cnt_q;
    rframe_d = rframe_q;
    slip = 1'b0;
    if (r_fslot) begin
      ph_d = !ph_q;
      rframe_d = rframe_nx;
      case (st_q)
        tfs_pkg::RX_FRAME_HUNT: begin
          if (!ph_q) begin
            if (r_alt) begin
              retry_d = 1'b0;
              cnt_d = cnt_q + 8'h01;
              if (cnt_q == 8'(LOCK_FRAMES - 1)) begin
                st_d = tfs_pkg::RX_MF_HUNT;
                cnt_d = 8'h00;
              end
            end else if (cnt_q != 8'h00) begin
              // one broken pair after good ones (a line hit) restarts the
              // count in place; moving phase here would end in a slip
              cnt_d = 8'h00;
            end else if (!retry_q) begin
              // try the other phase before moving the bit position
              retry_d = 1'b1;
              ph_d = ph_q;
              cnt_d = 8'h00;
            end else begin
              retry_d = 1'b0;
              cnt_d = 8'h00;
              slip = 1'b1;
            end
          end
        end
        tfs_pkg::RX_MF_HUNT: begin
          if (!ph_q && !r_alt) begin
            st_d = tfs_pkg::RX_FRAME_HUNT;
          end else if (ph_q && fs_next == tfs_pkg::SIGF_PATTERN) begin
            rframe_d = tfs_pkg::LAST_FRAME;
            st_d = tfs_pkg::RX_LOCKED;
          end
        end
        tfs_pkg::RX_LOCKED: begin
          if (r_fbit_ok) begin
            cnt_d = 8'h00;
          end else if (cnt_q == 8'(LOSS_ERRORS - 1)) begin
            st_d = tfs_pkg::RX_FRAME_HUNT;
            cnt_d = 8'h00;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        default: begin
          st_d = tfs_pkg::RX_FRAME_HUNT;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q <= tfs_pkg::RX_FRAME_HUNT;
      rpos_q <= tfs_pkg::F_POS;
      rframe_q <= tfs_pkg::FIRST_FRAME;
      fhist_q <= 2'h0;
      fs_sr_q <= 6'h00;
      ph_q <= 1'b0;
      retry_q <= 1'b0;
      cnt_q <= 8'h00;
      sh_q <= 7'h00;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      retry_q <= retry_d;
      cnt_q <= cnt_d;
      rframe_q <= rframe_d;
      if (r_fslot) begin
        fhist_q <= {fhist_q[0], rbit_q};
        if (ph_q) begin
          fs_sr_q <= fs_next;
        end
      end
      // a slip holds the count so the next bit is tried as the f-bit
      if (RX_TICK_IN && !slip) begin
        rpos_q <= (rpos_q == tfs_pkg::LAST_POS) ?
                  tfs_pkg::F_POS : rpos_q + 8'h01;
        sh_q <= {sh_q[5:0], rbit_q};
      end
    end
  end

  // ****************************************
  // receive octet delivery
  // ****************************************
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      RX_VALID_OUT <= 1'b0;
      RX_OCTET_OUT <= '0;
      RX_FRAME_LOCK_OUT <= 1'b0;
      RX_MF_LOCK_OUT <= 1'b0;
      RX_RALARM_OUT <= 1'b0;
      RX_RBIT_VALID_OUT <= 1'b0;
      RX_RBIT_OUT <= 1'b0;
      RX_SYNC_ERR_OUT <= 1'b0;
    end else begin
      RX_FRAME_LOCK_OUT <= r_aligned;
      RX_MF_LOCK_OUT <= r_locked;
      RX_VALID_OUT <= r_chan_end && r_aligned;
      RX_RBIT_VALID_OUT <= r_chan_end && r_dds && r_sync_ok;
      RX_SYNC_ERR_OUT <= r_chan_end && r_dds && !r_sync_ok;
      if (r_chan_end) begin
        RX_OCTET_OUT.data <= r_byte;
        RX_OCTET_OUT.chan <= r_chan;
        RX_OCTET_OUT.frame <= rframe_q;
        RX_OCTET_OUT.sig_valid <= r_sig;
        RX_OCTET_OUT.sig_is_b <= rframe_q == tfs_pkg::SIG_B_FRAME;
      end
      if (r_chan_end && r_dds && r_sync_ok) begin
        RX_RALARM_OUT <= !r_byte[tfs_pkg::SYNC_Y_BIT];
        RX_RBIT_OUT <= r_byte[tfs_pkg::SYNC_R_BIT];
      end
    end
  end

endmodule

/* File: common/tfs_pkg.sv */
// package for the twelve-frame t1 multiframe framer
// assumes one clock domain; all users refer to names as tfs_pkg::name
package tfs_pkg;

  // ****************************************
  // frame geometry
  // ****************************************
  localparam int BITS_PER_CHAN = 8;
  localparam int CHANNELS = 24;
  localparam int BITS_PER_FRAME = 1 + CHANNELS * BITS_PER_CHAN;
  localparam int FRAMES = 12;
  localparam int CHAN_RATE_KBPS = 64;
  localparam logic [7:0] LAST_POS = 8'(BITS_PER_FRAME - 1);
  localparam logic [7:0] F_POS = 8'h00;
  localparam logic [2:0] CHAN_END = 3'h0;
  localparam logic [4:0] LAST_CHAN = 5'(CHANNELS - 1);
  localparam logic [3:0] FIRST_FRAME = 4'h1;
  localparam logic [3:0] LAST_FRAME = 4'(FRAMES);
  localparam logic [3:0] SIG_A_FRAME = 4'h6;
  localparam logic [3:0] SIG_B_FRAME = 4'hc;

  // ****************************************
  // framing bit patterns, first frame in the msb
  // ****************************************
  localparam logic [5:0] TERM_PATTERN = 6'h2a;
  localparam logic [5:0] SIGF_PATTERN = 6'h0e;

  // ****************************************
  // digital data sync byte, line bit 1 in the msb
  // ****************************************
  localparam logic [7:0] SYNC_MASK = 8'hf9;
  localparam logic [7:0] SYNC_FIXED = 8'hb8;
  localparam int SYNC_Y_BIT = 2;
  localparam int SYNC_R_BIT = 1;

  typedef enum logic [1:0] {
    RX_FRAME_HUNT,
    RX_MF_HUNT,
    RX_LOCKED
  } tfs_rx_state_e;

  typedef struct packed {
    logic [7:0] data;
    logic [4:0] chan;
    logic [3:0] frame;
    logic sig_valid;
    logic sig_is_b;
  } tfs_rx_octet_s;

  // expected framing bit at the start of frame f (1..12)
  function automatic logic fbit(input logic [3:0] f);
    logic [3:0] k;
    k = 4'((f - FIRST_FRAME) >> 1);
    if (f[0]) begin
      fbit = TERM_PATTERN[3'(5 - k)];
    end else begin
      fbit = SIGF_PATTERN[3'(5 - k)];
    end
  endfunction

endpackage

/* File: tb/tfs_far_end.sv */
// far terminal model: loops the sent line back toward the receiver
// assumes the bench raises fault_in only to corrupt whole frames
`timescale 1ns/1ps
module tfs_far_end (
  // line
  input wire logic line_in,
  input wire logic fault_in,
  output logic line_out
);
  // framing, robbed bits and sync bytes are relayed, every bit inverted while fault_in is high
  assign line_out = line_in ^ fault_in;
endmodule

/* File: tb/tfs_checker.sv */
// assertions on the framer top ports
// assumes one clock, RST_IN synchronous active high
`timescale 1ns/1ps
module tfs_checker (
  // watched ports
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic DATA_MODE_IN,
  input wire logic TX_TICK_IN,
  input wire logic TX_REQ_OUT,
  input wire logic [4:0] TX_CHAN_OUT,
  input wire logic TX_BIT_OUT,
  input wire logic [3:0] TX_FRAME_OUT,
  input wire logic TX_MF_START_OUT,
  input wire logic RX_VALID_OUT,
  input wire tfs_pkg::tfs_rx_octet_s RX_OCTET_OUT,
  input wire logic RX_FRAME_LOCK_OUT,
  input wire logic RX_MF_LOCK_OUT,
  input wire logic RX_RBIT_VALID_OUT,
  input wire logic RX_SYNC_ERR_OUT
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  wire sig_v = RX_VALID_OUT && RX_OCTET_OUT.sig_valid;
  wire [3:0] rf = RX_OCTET_OUT.frame;
  // the tick of an f bit always asks for channel 0 next
  sequence f_req_s;
    $past(TX_TICK_IN) && TX_REQ_OUT && TX_CHAN_OUT == 5'h00;
  endsequence
  AST_FRAME_STEP: assert property (!$past(RST_IN) && $changed(TX_FRAME_OUT)
    |-> TX_FRAME_OUT == $past(TX_FRAME_OUT) % 12 + 1)
    else $error("frame number did not step by one");
  AST_MF_START: assert property (TX_MF_START_OUT |->
    TX_FRAME_OUT == 4'h1 && TX_BIT_OUT ##0 f_req_s)
    else $error("multiframe start without frame one f bit");
  AST_BIT_HOLD: assert property (!$past(RST_IN) && !$past(TX_TICK_IN)
    |-> $stable(TX_BIT_OUT) && $stable(TX_FRAME_OUT))
    else $error("line bit moved without a tick");
  AST_CHAN: assert property (TX_REQ_OUT |->
    $past(TX_TICK_IN) && TX_CHAN_OUT <= 5'h17)
    else $error("bad channel request");
  AST_RX_LOCK: assert property (RX_VALID_OUT |->
    RX_FRAME_LOCK_OUT || $past(RX_FRAME_LOCK_OUT))
    else $error("octet delivered while hunting");
  AST_MF_AFTER_FRAME: assert property ($rose(RX_MF_LOCK_OUT) |->
    RX_FRAME_LOCK_OUT && $past(RX_FRAME_LOCK_OUT))
    else $error("multiframe lock before frame lock");
  AST_SIG: assert property (sig_v |-> !DATA_MODE_IN &&
    (RX_MF_LOCK_OUT || $past(RX_MF_LOCK_OUT)) && (rf == 4'h6 || rf == 4'hc))
    else $error("signalling flagged in wrong frame");
  AST_SIG_B: assert property (sig_v |->
    RX_OCTET_OUT.sig_is_b == (rf == 4'hc))
    else $error("signalling a and b mixed up");
  AST_SYNC: assert property (RX_SYNC_ERR_OUT || RX_RBIT_VALID_OUT |->
    DATA_MODE_IN && RX_VALID_OUT && RX_OCTET_OUT.chan == 5'h17)
    else $error("sync byte event outside last channel");
endmodule
bind tfs_framer tfs_checker chk_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .DATA_MODE_IN(DATA_MODE_IN), .TX_TICK_IN(TX_TICK_IN),
  .TX_REQ_OUT(TX_REQ_OUT), .TX_CHAN_OUT(TX_CHAN_OUT),
  .TX_BIT_OUT(TX_BIT_OUT), .TX_FRAME_OUT(TX_FRAME_OUT),
  .TX_MF_START_OUT(TX_MF_START_OUT), .RX_VALID_OUT(RX_VALID_OUT),
  .RX_OCTET_OUT(RX_OCTET_OUT), .RX_FRAME_LOCK_OUT(RX_FRAME_LOCK_OUT),
  .RX_MF_LOCK_OUT(RX_MF_LOCK_OUT), .RX_RBIT_VALID_OUT(RX_RBIT_VALID_OUT),
  .RX_SYNC_ERR_OUT(RX_SYNC_ERR_OUT));

/* File: tb/tfs_framer_bench.sv */
// self-checking bench: framer with a looped-back far terminal
// assumes ticks every 7 clocks so the line settles before rx sampling
`timescale 1ns/1ps
module tfs_framer_bench;
  // ********
  // signals and helpers
  // ********
  logic clk, rst, mode, mode_req, txt, rxt, ral_tx, rb_tx, fault;
  logic run, tick_d, settled, lost, rx_line;
  logic [7:0] txd, rnd, cur;
  logic [23:0] sa, sb;
  logic req, txbit, mfs, rxv, flk, mlk, ral, rbv, rb, serr;
  logic [4:0] ch;
  logic [3:0] fr;
  tfs_pkg::tfs_rx_octet_s oct;
  logic [7:0] sent [1:12][0:23];
  logic [5:0] q [$];
  int bad_count, cmp_count, cnt, p, f;
  // f bits of frames 1..12, frame 1 in the msb
  localparam logic [11:0] FPAT = 12'h8dc;
  localparam int FR = 1351;
  tfs_framer dut_u (.CLK_IN(clk), .RST_IN(rst), .DATA_MODE_IN(mode),
    .TX_TICK_IN(txt), .TX_DATA_IN(txd), .TX_SIG_A_IN(sa), .TX_SIG_B_IN(sb),
    .TX_RALARM_IN(ral_tx), .TX_RBIT_IN(rb_tx), .TX_REQ_OUT(req),
    .TX_CHAN_OUT(ch), .TX_BIT_OUT(txbit), .TX_FRAME_OUT(fr),
    .TX_MF_START_OUT(mfs), .RX_TICK_IN(rxt), .RX_LINE_IN(rx_line),
    .RX_VALID_OUT(rxv), .RX_OCTET_OUT(oct), .RX_FRAME_LOCK_OUT(flk),
    .RX_MF_LOCK_OUT(mlk), .RX_RALARM_OUT(ral), .RX_RBIT_VALID_OUT(rbv),
    .RX_RBIT_OUT(rb), .RX_SYNC_ERR_OUT(serr));
  tfs_far_end far_u (.line_in(txbit), .fault_in(fault), .line_out(rx_line));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // notes the expected line bit of this tick
  task automatic send_bit();
    logic [7:0] byt;
    int c;
    c = (p - 1) / 8;
    if (p == 0 && f == 1) mode = mode_req;
    if (p == 0) begin
      rnd = lfsr(rnd);
      sa = {rnd, ~rnd, rnd};
      sb = {~rnd, rnd, rnd};
      ral_tx = rnd[0];
      rb_tx = rnd[3];
    end
    if (p % 8 == 1) cur = txd;
    byt = mode && c == 23 ? {5'h17, ~ral_tx, rb_tx, 1'h0} : cur;
    if (!mode && (f == 6 || f == 12)) byt[0] = f == 6 ? sa[c] : sb[c];
    q.push_back({p == 0 && f == 1, 4'(f),
      p == 0 ? FPAT[12 - f] : byt[7 - (p - 1) % 8]});
    if (p % 8 == 0 && p > 0) sent[f][c] = byt;
    p = (p + 1) % 193;
    if (p == 0) f = f % 12 + 1;
  endtask
  task automatic wait_lock();
    for (int i = 0; i < 30 * FR && mlk !== 1'b1; i++) @(posedge clk);
    check(8'(mlk), 8'h01);
  endtask
  // ********
  // drivers and watcher
  // ********
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // rx tick five clocks after tx tick: synchroniser delay plus margin
  always @(negedge clk) begin
    txt = run && cnt == 0;
    rxt = run && cnt == 5;
    if (req === 1'b1) begin
      rnd = lfsr(rnd);
      txd = rnd;
    end
    if (txt) send_bit();
    if (run) cnt = (cnt + 1) % 7;
  end
  always @(posedge clk) tick_d <= txt;
  always @(negedge clk) begin
    logic e;
    e = !mode && (oct.frame == 4'h6 || oct.frame == 4'hc);
    if (tick_d && q.size() > 0)
      check(8'({mfs, fr, txbit}), 8'(q.pop_front()));
    if (fault && flk === 1'b0) lost = 1'b1;
    if (settled && rxv === 1'b1) begin
      check(oct.data, sent[oct.frame][oct.chan]);
      check(8'({rbv, serr}), 8'({mode && oct.chan == 23, 1'b0}));
      check(8'({oct.sig_valid, oct.sig_valid && oct.sig_is_b}),
        8'({e, e && oct.frame == 4'hc}));
    end
    if (settled && rbv === 1'b1) begin
      check(8'(rb), 8'(sent[oct.frame][23][1]));
      check(8'(ral), 8'(!sent[oct.frame][23][2]));
    end
  end
  initial begin
    #(70 * FR * 20);
    bad_count++;
    report_and_stop();
  end
  initial begin
    {rst, run, mode, mode_req, txt, rxt, ral_tx, rb_tx, fault} = 9'h100;
    {settled, lost, tick_d, txd, cur, sa, sb} = '0;
    rnd = 8'h1c;
    {cnt, p, f, bad_count, cmp_count} = {32'h0, 32'h0, 32'h1, 64'h0};
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    run = 1'b1;
    wait_lock();
    settled = 1'b1;
    repeat (12 * FR) @(posedge clk);
    check(8'(mlk), 8'h01);
    settled = 1'b0;
    @(negedge clk);
    fault = 1'b1;
    repeat (5 * FR) @(posedge clk);
    @(negedge clk);
    fault = 1'b0;
    mode_req = 1'b1;
    check(8'(lost), 8'h01);
    wait_lock();
    settled = 1'b1;
    repeat (12 * FR) @(posedge clk);
    report_and_stop();
  end
endmodule
